// ---- bench/gcf_flags_sva.sv ----
// Port checker for the command decoder and flag byte
`timescale 1ns/1ps
`default_nettype none
`include "gcf_defines.vh"
// ============================================================
// Checker
module gcf_flags_sva #(
    parameter BLINK_HALF = 8
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic tx_bit_req_i,
    input wire logic tx_bit_valid_o,
    input wire logic reg_wr_o,
    input wire logic [`GCF_ADDR_W-1:0] target_address_field_o,
    input wire logic sense_above_thresh_i,
    input wire logic discharge_active_i,
    input wire logic sense_above_max_i,
    input wire logic sense_above_low_i,
    input wire logic sense_below_first_i,
    input wire logic sense_overload_i,
    input wire logic valid_charge_i,
    input wire logic charge_ctl_pin_i,
    input wire logic [`GCF_BYTE_W-1:0] primary_flag_byte_o,
    input wire logic overload_flag_o,
    input wire logic [`GCF_SEG_W-1:0] seg_o,
    input wire logic empty_oe_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Charge, absent, permit and overload checks wait one edge after reset so reset-time inputs do not count
    a_answer_after_request: assert property (tx_bit_valid_o |-> $past(tx_bit_req_i))
        else $error("read bit without request");
    a_flag_byte_unwritable: assert property (reg_wr_o |-> target_address_field_o > `GCF_ADDR_FLAGS)
        else $error("write pulse to command or flag address");
    a_charge_status: assert property ($past(reset_n_i) |->
        primary_flag_byte_o[7] == $past(sense_above_thresh_i && !discharge_active_i))
        else $error("charge status wrong");
    a_absent_level: assert property ($past(reset_n_i) |->
        primary_flag_byte_o[5] == $past(sense_above_max_i || !sense_above_low_i))
        else $error("pack absent wrong");
    a_permit_mirror: assert property ($past(reset_n_i) |->
        primary_flag_byte_o[2] == $past(charge_ctl_pin_i))
        else $error("permit bit wrong");
    a_overload_delay: assert property ($past(reset_n_i) |-> overload_flag_o == $past(sense_overload_i))
        else $error("overload flag wrong");
    a_warn_cause: assert property ($rose(primary_flag_byte_o[1]) |->
        $past(sense_below_first_i && !sense_overload_i && !overload_flag_o))
        else $error("first warning without cause");
    a_warn_latched: assert property (primary_flag_byte_o[1] && !valid_charge_i |=> primary_flag_byte_o[1])
        else $error("first warning dropped");
    a_final_dark: assert property (primary_flag_byte_o[0] |-> seg_o == '0)
        else $error("segments lit under final warning");
    a_empty_release: assert property (empty_oe_n_o == primary_flag_byte_o[1])
        else $error("empty output state wrong");
    c_write: cover property (reg_wr_o);
    c_read: cover property (tx_bit_valid_o);
    c_final: cover property ($rose(primary_flag_byte_o[0]));
endmodule // gcf_flags_sva
bind gcf_flags gcf_flags_sva #(.BLINK_HALF(BLINK_HALF)) u_sva (.core_clk_i, .reset_n_i, .tx_bit_req_i,
    .tx_bit_valid_o, .reg_wr_o, .target_address_field_o, .sense_above_thresh_i, .discharge_active_i,
    .sense_above_max_i, .sense_above_low_i, .sense_below_first_i, .sense_overload_i, .valid_charge_i,
    .charge_ctl_pin_i, .primary_flag_byte_o, .overload_flag_o, .seg_o, .empty_oe_n_o);
`default_nettype wire

// ---- bench/gcf_flags_test.sv ----
// Self-checking bench for the command decoder and flag byte
`timescale 1ns/1ps
`default_nettype none
`include "gcf_defines.vh"
// ============================================================
// Bench top
module gcf_flags_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic thr = 0, dis = 0, smax = 0, slow = 1, sfir = 0, sfin = 0, ovl = 0;
    logic aeq = 0, sdo = 0, tbz = 0, pin = 0, den = 0, owr = 1;
    logic [2:0] pl = 3'h0;
    logic [5:0] segd = 6'h3f;
    logic [7:0] odat = 8'h3c;
    logic brkd, rxv, rxb, txr, txb, txv, wr, ovf, eoe, eo;
    logic [6:0] adr;
    logic [7:0] wdat, pfb, d;
    logic [5:0] seg;
    int bad_count = 0, cmp_count = 0, wr_cnt = 0, h;
    // Clock, 4 ns period
    always #2 clk = ~clk;
    // Count write pulses to the other registers
    always @(posedge clk) if (wr === 1'b1) wr_cnt <= wr_cnt + 1;
    gcf_host_model host (.core_clk_i(clk), .tx_bit_o(txb), .tx_bit_valid_o(txv), .break_done_o(brkd),
        .rx_bit_valid_o(rxv), .rx_bit_o(rxb), .tx_bit_req_o(txr));
    // Short blink half period keeps the run small
    gcf_flags #(.BLINK_HALF(8)) dut (.core_clk_i(clk), .reset_n_i(rst_n), .break_done_i(brkd),
        .rx_bit_valid_i(rxv), .rx_bit_i(rxb), .tx_bit_req_i(txr), .tx_bit_o(txb), .tx_bit_valid_o(txv),
        .target_address_field_o(adr), .reg_wr_o(wr), .reg_wdata_o(wdat), .other_rdata_i(odat),
        .other_writable_i(owr), .sense_above_thresh_i(thr), .discharge_active_i(dis),
        .sense_above_max_i(smax), .sense_above_low_i(slow), .sense_below_first_i(sfir),
        .sense_below_final_i(sfin), .sense_overload_i(ovl), .valid_charge_i(pl[0]), .charge_count_i(pl[1]),
        .avail_eq_capacity_i(aeq), .capacity_update_i(pl[2]), .self_discharge_over_i(sdo),
        .temp_below_zero_i(tbz), .charge_ctl_pin_i(pin), .display_en_i(den), .seg_drive_i(segd),
        .primary_flag_byte_o(pfb), .overload_flag_o(ovf), .seg_o(seg), .empty_o(eo), .empty_oe_n_o(eoe));
    // ============================================================
    // Tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        host.brk();
        host.send({`GCF_DIR_READ, a});
        host.recv(v);
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        host.brk();
        host.send({`GCF_DIR_WRITE, a});
        host.send(v);
        step(3);
    endtask
    // Pulse mask bits: 0 valid charge, 1 charge count, 2 capacity update
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(negedge clk);
            pl = m;
            @(negedge clk);
            pl = 3'h0;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the roughly one thousand cycles the tests need
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
    // ============================================================
    // Test sequence
    initial begin
        step(4);
        rst_n = 1'b1;
        rd(`GCF_ADDR_FLAGS, d); chk("flags after reset", `GCF_FLAGS_RESET, d);
        chkb("empty level", 0, eo);
        chk("segments", 8'h3f, {2'h0, seg});
        wr_reg(`GCF_ADDR_FLAGS, 8'hff); chk("write pulses", 8'h0, 8'(wr_cnt));
        rd(`GCF_ADDR_FLAGS, d); chk("flags after write", `GCF_FLAGS_RESET, d);
        owr = 0;
        wr_reg(7'h04, 8'hb1); chk("write pulses", 8'h0, 8'(wr_cnt));
        owr = 1;
        wr_reg(7'h04, 8'hb1); chk("write pulses", 8'h1, 8'(wr_cnt));
        chk("write data", 8'hb1, wdat);
        chk("write address", 8'h04, {1'b0, adr});
        host.send(8'h84); host.send(8'h55); step(3); chk("write pulses", 8'h1, 8'(wr_cnt));
        rd(7'h05, d); chk("other read", 8'h3c, d);
        pin = 1; step(1); chkb("permit", 1, pfb[2]);
        pin = 0; thr = 1; step(1); chkb("charging", 1, pfb[7]);
        dis = 1; step(1); chkb("charging", 0, pfb[7]);
        dis = 0; thr = 0; aeq = 1; pulse(3'h1, 1); chkb("replaced", 0, pfb[6]);
        // Fall from above the maximum level meets a clearing charge: the set must win
        smax = 1; step(1); chkb("absent", 1, pfb[5]);
        smax = 0; pl = 3'h1; step(1); pl = 3'h0; chkb("replaced", 1, pfb[6]);
        pulse(3'h1, 1); chkb("replaced", 0, pfb[6]);
        aeq = 0; slow = 0; step(1); chkb("absent", 1, pfb[5]);
        slow = 1; step(1); chkb("replaced", 1, pfb[6]);
        chkb("absent", 0, pfb[5]);
        pulse(3'h4, 1); chkb("doubt", 0, pfb[4]);
        pulse(3'h1, 63); chkb("doubt", 0, pfb[4]);
        pulse(3'h1, 1); chkb("doubt", 1, pfb[4]);
        aeq = 1; dis = 1; step(1); chkb("qualified", 1, pfb[3]);
        dis = 0; aeq = 0; sdo = 1; step(1); chkb("qualified", 0, pfb[3]);
        sdo = 0; aeq = 1; dis = 1; step(1);
        dis = 0; aeq = 0; thr = 1; pulse(3'h2, 255); chkb("qualified", 1, pfb[3]);
        pulse(3'h2, 1); chkb("qualified", 0, pfb[3]);
        aeq = 1; dis = 1; step(1); chkb("qualified", 1, pfb[3]);
        // Below freezing, so the first warning must also drop the qualified discharge
        dis = 0; aeq = 0; tbz = 1;
        thr = 0; ovl = 1; sfir = 1; step(2); chkb("first warning", 0, pfb[1]);
        chkb("overload", 1, ovf);
        chkb("qualified", 1, pfb[3]);
        chkb("empty released", 0, eoe);
        ovl = 0; step(2); chkb("first warning", 1, pfb[1]);
        chkb("qualified", 0, pfb[3]);
        chkb("empty released", 1, eoe);
        // Half period 8: about 20 of 40 cycles lit whatever the phase
        den = 1; h = 0;
        repeat (40) begin
            @(negedge clk);
            h += seg[0];
        end
        chkb("blink", 1, h >= 16 && h <= 24);
        den = 0; sfin = 1; step(1); chkb("final warning", 1, pfb[0]);
        chk("segments", 8'h0, {2'h0, seg});
        sfir = 0; sfin = 0; step(1); chk("warnings", 8'h3, {6'h0, pfb[1:0]});
        pulse(3'h1, 1); rd(`GCF_ADDR_FLAGS, d); chk("flags after charge", 8'h10, d);
        rst_n = 1'b0; step(2); rst_n = 1'b1;
        rd(`GCF_ADDR_FLAGS, d); chk("flags after reset", `GCF_FLAGS_RESET, d);
        tally_and_finish();
    end
endmodule // gcf_flags_test
`default_nettype wire

// ---- bench/gcf_host_model.sv ----
// Host model on the framed side of the serial link
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host: break, LSB-first bytes, read requests
module gcf_host_model (
    input wire logic core_clk_i,
    input wire logic tx_bit_o,
    input wire logic tx_bit_valid_o,
    output var logic break_done_o,
    output var logic rx_bit_valid_o,
    output var logic rx_bit_o,
    output var logic tx_bit_req_o
);
    // Idle link at time zero
    initial begin
        break_done_o = 1'b0;
        rx_bit_valid_o = 1'b0;
        rx_bit_o = 1'b1;
        tx_bit_req_o = 1'b0;
    end
    // Break opens every transaction
    task automatic brk();
        @(negedge core_clk_i);
        break_done_o = 1'b1;
        @(negedge core_clk_i);
        break_done_o = 1'b0;
    endtask
    // Two cycles a bit keeps clear of the decode cycle; idle shows the inverse
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk_i);
            rx_bit_valid_o = 1'b1;
            rx_bit_o = b[i];
            @(negedge core_clk_i);
            rx_bit_valid_o = 1'b0;
            rx_bit_o = ~b[i];
        end
    endtask
    // A missing answer reads as unknown so the compare catches it
    task automatic recv(output logic [7:0] b);
        @(negedge core_clk_i);
        for (int i = 0; i < 8; i++) begin
            tx_bit_req_o = 1'b1;
            @(negedge core_clk_i);
            tx_bit_req_o = 1'b0;
            b[i] = tx_bit_valid_o ? tx_bit_o : 1'bx;
            @(negedge core_clk_i);
        end
    endtask
endmodule // gcf_host_model
`default_nettype wire

// ---- inc/gcf_defines.vh ----
// Constants for the gauge command decoder and primary flag byte
`ifndef GCF_DEFINES_VH
`define GCF_DEFINES_VH

// ============================================================
// Command byte layout
`define GCF_BYTE_W 8
`define GCF_CMD_DIR_BIT 7
`define GCF_ADDR_HI 6
`define GCF_ADDR_W 7
`define GCF_DIR_READ 1'h0
`define GCF_DIR_WRITE 1'h1

// ============================================================
// Register addresses
`define GCF_ADDR_CMD 7'h00
`define GCF_ADDR_FLAGS 7'h01

// ============================================================
// Primary flag byte bit positions
`define GCF_BIT_CHARGING_DETECTED 7
`define GCF_BIT_REPL 6
`define GCF_BIT_ABSENT 5
`define GCF_BIT_DOUBT 4
`define GCF_BIT_QDIS 3
`define GCF_BIT_PERMIT 2
`define GCF_BIT_LOW1 1
`define GCF_BIT_LOWF 0
`define GCF_FLAGS_RESET 8'h50

// ============================================================
// Counts
`define GCF_BIT_CNT_W 4
`define GCF_BITS_PER_BYTE 4'h8
`define GCF_DOUBT_CNT_W 8
`define GCF_DOUBT_SET_AT 8'h40
`define GCF_DOUBT_SAT 8'hff
`define GCF_SUST_CNT_W 9
`define GCF_SUST_LIMIT 9'h100
`define GCF_SEG_W 6

// ============================================================
// Timing: 4 Hz blink at a 250 MHz core clock
`define GCF_CLK_HZ 250000000
`define GCF_BLINK_HZ 4
`define GCF_BLINK_CNT_W 25

// ============================================================
// Command state machine codes
`define GCF_ST_IDLE 2'h0
`define GCF_ST_CMD 2'h1
`define GCF_ST_WDATA 2'h2
`define GCF_ST_RDATA 2'h3

`endif

// ---- logic/gcf_flags.v ----
// Command decoder and primary flag byte of the charge monitor
// Behaviour
// - Command loads only after eight bits; not readable
// - Bit 7: zero reads, one writes next byte
// - Low seven bits address; bad writes dropped
// - Flag byte at 01h, read-only
// - Charge status follows threshold, cleared by discharge
// - Replaced set on falling-from-max or rising-above-low
// - Replaced set by every reset
// - Replaced cleared by full charge or post-warning charge
// - Absent high while sense outside limits
// - Doubt on 64th charge or reset; update clears
// - Qualified discharge set leaving full charge
// - Self-discharge overflow clears qualified discharge
// - 256 sustained charge counts clear qualified discharge
// - First warning below freezing clears qualified discharge
// - Permit bit mirrors charge-control pin
// - First warning below 1.05V unless overloaded
// - First segment blinks 4Hz under first warning
// - Final warning below 0.95V unless overloaded
// - Final warning turns all segments off
// - Empty output released on first warning
// - All bytes travel least significant bit first
// - Command accepted only after a break
// - Overload flag blocks end-of-discharge warnings
`timescale 1ns/1ps
`default_nettype none
`include "gcf_defines.vh"

module gcf_flags #(
    parameter BLINK_HALF = `GCF_CLK_HZ / (2 * `GCF_BLINK_HZ)
) (
    input wire core_clk_i,
    input wire reset_n_i,
    // Bit-level link framing
    input wire break_done_i,
    input wire rx_bit_valid_i,
    input wire rx_bit_i,
    input wire tx_bit_req_i,
    output reg tx_bit_o,
    output reg tx_bit_valid_o,
    // Other registers of the device
    output reg [`GCF_ADDR_W-1:0] target_address_field_o,
    output reg reg_wr_o,
    output reg [`GCF_BYTE_W-1:0] reg_wdata_o,
    input wire [`GCF_BYTE_W-1:0] other_rdata_i,
    input wire other_writable_i,
    // Measurement results
    input wire sense_above_thresh_i,
    input wire discharge_active_i,
    input wire sense_above_max_i,
    input wire sense_above_low_i,
    input wire sense_below_first_i,
    input wire sense_below_final_i,
    input wire sense_overload_i,
    input wire valid_charge_i,
    input wire charge_count_i,
    input wire avail_eq_capacity_i,
    input wire capacity_update_i,
    input wire self_discharge_over_i,
    input wire temp_below_zero_i,
    input wire charge_ctl_pin_i,
    input wire display_en_i,
    input wire [`GCF_SEG_W-1:0] seg_drive_i,
    // Status and pins
    output reg [`GCF_BYTE_W-1:0] primary_flag_byte_o,
    output reg overload_flag_o,
    output reg [`GCF_SEG_W-1:0] seg_o,
    output reg empty_o,
    output reg empty_oe_n_o
);

    // ============================================================
    // Declarations
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`GCF_BYTE_W-1:0] command_word;
    reg [`GCF_BYTE_W-1:0] flags;
    reg [`GCF_BYTE_W-1:0] next_flags;
    reg max_prev;
    reg low_prev;
    reg dis_prev;
    reg [`GCF_DOUBT_CNT_W-1:0] doubt_cnt;
    reg [`GCF_SUST_CNT_W-1:0] sust_cnt;
    reg [`GCF_BLINK_CNT_W-1:0] blink_cnt;
    reg blink_phase;
    reg sh_clear;
    reg sh_load;
    reg sh_shift;
    reg [`GCF_BYTE_W-1:0] sh_load_data;
    wire [`GCF_BYTE_W-1:0] sh_data;
    wire sh_lsb;
    wire sh_full;
    wire [`GCF_BYTE_W-1:0] rdata;
    wire charging;
    wire warn_ok;
    wire repl_set;
    wire repl_clr;
    wire doubt_set;
    wire qdis_set;
    wire qdis_clr;
    wire low1_set;
    wire lowf_set;
    wire sust_hit;

    // ============================================================
    // Shared shift register for command, write data and read data
    gcf_shift8 u_shift (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(sh_clear),
        .load_i(sh_load),
        .load_data_i(sh_load_data),
        .shift_i(sh_shift),
        .bit_i(rx_bit_i),
        .data_o(sh_data),
        .lsb_o(sh_lsb),
        .full_o(sh_full)
    );

    // Read mux: flag byte at its own address, rest from outside
    assign rdata = (sh_data[`GCF_ADDR_HI:0] == `GCF_ADDR_FLAGS) ? flags : other_rdata_i;

    // ============================================================
    // Command sequencing; a break restarts from any state
    always @* begin
        next_state = state;
        sh_clear = 1'b0;
        sh_load = 1'b0;
        sh_shift = 1'b0;
        sh_load_data = rdata;
        if (break_done_i) begin
            next_state = `GCF_ST_CMD;
            sh_clear = 1'b1;
        end else begin
            case (state)
                `GCF_ST_IDLE: begin
                    next_state = `GCF_ST_IDLE;
                end
                `GCF_ST_CMD: begin
                    if (sh_full) begin
                        if (sh_data[`GCF_CMD_DIR_BIT] == `GCF_DIR_WRITE) begin
                            next_state = `GCF_ST_WDATA;
                            sh_clear = 1'b1;
                        end else begin
                            next_state = `GCF_ST_RDATA;
                            sh_load = 1'b1;
                        end
                    end else begin
                        sh_shift = rx_bit_valid_i;
                    end
                end
                `GCF_ST_WDATA: begin
                    if (sh_full) begin
                        next_state = `GCF_ST_IDLE;
                    end else begin
                        sh_shift = rx_bit_valid_i;
                    end
                end
                `GCF_ST_RDATA: begin
                    if (sh_full) begin
                        next_state = `GCF_ST_IDLE;
                    end else begin
                        sh_shift = tx_bit_req_i;
                    end
                end
                default: begin
                    next_state = `GCF_ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // State, command latch, outgoing bits and write strobes
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= `GCF_ST_IDLE;
            command_word <= {`GCF_BYTE_W{1'b0}};
            target_address_field_o <= {`GCF_ADDR_W{1'b0}};
            reg_wr_o <= 1'b0;
            reg_wdata_o <= {`GCF_BYTE_W{1'b0}};
            tx_bit_o <= 1'b0;
            tx_bit_valid_o <= 1'b0;
        end else begin
            state <= next_state;
            reg_wr_o <= 1'b0;
            tx_bit_valid_o <= 1'b0;
            // Command held only once all eight bits are in
            if (!break_done_i && state == `GCF_ST_CMD && sh_full) begin
                command_word <= sh_data;
                target_address_field_o <= sh_data[`GCF_ADDR_HI:0];
            end
            // Writes to the flag byte or unwritable addresses vanish
            if (!break_done_i && state == `GCF_ST_WDATA && sh_full) begin
                reg_wdata_o <= sh_data;
                reg_wr_o <= other_writable_i &&
                    (command_word[`GCF_ADDR_HI:0] != `GCF_ADDR_FLAGS) &&
                    (command_word[`GCF_ADDR_HI:0] != `GCF_ADDR_CMD);
            end
            // Each request sends the current low bit
            if (!break_done_i && state == `GCF_ST_RDATA && !sh_full && tx_bit_req_i) begin
                tx_bit_o <= sh_lsb;
                tx_bit_valid_o <= 1'b1;
            end
        end
    end

    // ============================================================
    // Flag set and clear conditions
    assign charging = sense_above_thresh_i && !discharge_active_i;
    assign warn_ok = !overload_flag_o && !sense_overload_i;
    assign repl_set = (max_prev && !sense_above_max_i) || (!low_prev && sense_above_low_i);
    assign repl_clr = valid_charge_i && (avail_eq_capacity_i || flags[`GCF_BIT_LOW1]);
    assign doubt_set = valid_charge_i && (doubt_cnt == `GCF_DOUBT_SET_AT - 8'h01);
    assign qdis_set = discharge_active_i && !dis_prev && avail_eq_capacity_i;
    assign sust_hit = charge_count_i && charging &&
        (sust_cnt == `GCF_SUST_LIMIT - 9'h001);
    assign low1_set = sense_below_first_i && warn_ok;
    assign lowf_set = sense_below_final_i && warn_ok;
    assign qdis_clr = capacity_update_i || self_discharge_over_i || sust_hit ||
        (low1_set && !flags[`GCF_BIT_LOW1] && temp_below_zero_i);

    // Set takes priority over clear everywhere below
    always @* begin
        next_flags = flags;
        next_flags[`GCF_BIT_CHARGING_DETECTED] = charging;
        if (repl_set) begin
            next_flags[`GCF_BIT_REPL] = 1'b1;
        end else if (repl_clr) begin
            next_flags[`GCF_BIT_REPL] = 1'b0;
        end
        next_flags[`GCF_BIT_ABSENT] = sense_above_max_i || !sense_above_low_i;
        if (doubt_set) begin
            next_flags[`GCF_BIT_DOUBT] = 1'b1;
        end else if (capacity_update_i) begin
            next_flags[`GCF_BIT_DOUBT] = 1'b0;
        end
        if (qdis_set) begin
            next_flags[`GCF_BIT_QDIS] = 1'b1;
        end else if (qdis_clr) begin
            next_flags[`GCF_BIT_QDIS] = 1'b0;
        end
        next_flags[`GCF_BIT_PERMIT] = charge_ctl_pin_i;
        if (low1_set) begin
            next_flags[`GCF_BIT_LOW1] = 1'b1;
        end else if (valid_charge_i) begin
            next_flags[`GCF_BIT_LOW1] = 1'b0;
        end
        if (lowf_set) begin
            next_flags[`GCF_BIT_LOWF] = 1'b1;
        end else if (valid_charge_i) begin
            next_flags[`GCF_BIT_LOWF] = 1'b0;
        end
    end

    // ============================================================
    // Flag register; reset marks the pack replaced and capacity doubtful
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags <= `GCF_FLAGS_RESET;
            primary_flag_byte_o <= `GCF_FLAGS_RESET;
            overload_flag_o <= 1'b0;
            max_prev <= 1'b0;
            low_prev <= 1'b1;
            dis_prev <= 1'b0;
        end else begin
            flags <= next_flags;
            primary_flag_byte_o <= next_flags;
            overload_flag_o <= sense_overload_i;
            max_prev <= sense_above_max_i;
            low_prev <= sense_above_low_i;
            dis_prev <= discharge_active_i;
        end
    end

    // ============================================================
    // Charges since the last capacity update, saturating so it never wraps
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            doubt_cnt <= {`GCF_DOUBT_CNT_W{1'b0}};
        end else if (capacity_update_i) begin
            doubt_cnt <= {`GCF_DOUBT_CNT_W{1'b0}};
        end else if (valid_charge_i && doubt_cnt != `GCF_DOUBT_SAT) begin
            doubt_cnt <= doubt_cnt + 8'h01;
        end
    end

    // Sustained charge counts; any break in charging restarts the run
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sust_cnt <= {`GCF_SUST_CNT_W{1'b0}};
        end else if (!charging || sust_hit) begin
            sust_cnt <= {`GCF_SUST_CNT_W{1'b0}};
        end else if (charge_count_i) begin
            sust_cnt <= sust_cnt + 9'h001;
        end
    end

    // ============================================================
    // Blink divider: free running, so the phase is arbitrary at warning onset
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blink_cnt <= {`GCF_BLINK_CNT_W{1'b0}};
            blink_phase <= 1'b0;
        end else if (blink_cnt == BLINK_HALF[`GCF_BLINK_CNT_W-1:0] - 25'h1) begin
            blink_cnt <= {`GCF_BLINK_CNT_W{1'b0}};
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 25'h1;
        end
    end

    // ============================================================
    // Segment and empty pin drivers
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seg_o <= {`GCF_SEG_W{1'b0}};
            empty_o <= 1'b0;
            empty_oe_n_o <= 1'b0;
        end else begin
            if (next_flags[`GCF_BIT_LOWF]) begin
                seg_o <= {`GCF_SEG_W{1'b0}};
            end else if (next_flags[`GCF_BIT_LOW1] && display_en_i) begin
                seg_o <= {seg_drive_i[`GCF_SEG_W-1:1], blink_phase};
            end else begin
                seg_o <= seg_drive_i;
            end
            // Open drain: pulled low normally, released once low
            empty_o <= 1'b0;
            empty_oe_n_o <= next_flags[`GCF_BIT_LOW1];
        end
    end

endmodule // gcf_flags

`default_nettype wire

// ---- logic/gcf_shift8.v ----
// Eight-bit LSB-first shift register with a bit counter, shared by receive and send
`timescale 1ns/1ps
`default_nettype none
`include "gcf_defines.vh"

module gcf_shift8 (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire clear_i,
    input wire load_i,
    input wire [`GCF_BYTE_W-1:0] load_data_i,
    input wire shift_i,
    input wire bit_i,
    output reg [`GCF_BYTE_W-1:0] data_o,
    output wire lsb_o,
    output wire full_o
);

    reg [`GCF_BIT_CNT_W-1:0] count;

    assign lsb_o = data_o[0];
    assign full_o = (count == `GCF_BITS_PER_BYTE);

    // ============================================================
    // Shift right so the first bit in lands in bit 0 after eight shifts
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_o <= {`GCF_BYTE_W{1'b0}};
            count <= {`GCF_BIT_CNT_W{1'b0}};
        end else if (clear_i) begin
            count <= {`GCF_BIT_CNT_W{1'b0}};
        end else if (load_i) begin
            data_o <= load_data_i;
            count <= {`GCF_BIT_CNT_W{1'b0}};
        end else if (shift_i && !full_o) begin
            data_o <= {bit_i, data_o[`GCF_BYTE_W-1:1]};
            count <= count + 4'h1;
        end
    end

endmodule // gcf_shift8

`default_nettype wire
